// ---- rtl/tcpd_pkg.sv ----
package tcpd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register word addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COUNT = 8'h01;
    localparam logic [7:0] REG_RELOAD = 8'h02;
    localparam logic [7:0] REG_PWM = 8'h03;
    localparam logic [7:0] REG_DEADBAND = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;
    localparam logic [7:0] REG_MASK = 8'h06;
    localparam logic [7:0] REG_PINS = 8'h07;

    // Control field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_POL = 3;
    localparam int CTRL_OUTFN = 4;
    localparam int CTRL_PRESC_LO = 5;

    // Status and mask bit positions
    localparam int ST_RELOAD = 0;
    localparam int ST_MATCH = 1;

    // Reset, restart and limit values
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] COUNT_RESET = 16'h0001;
    localparam logic [15:0] RELOAD_RESET = 16'hffff;
    localparam logic [15:0] PWM_RESET = 16'h0000;
    localparam logic [7:0] DEADBAND_RESET = 8'h00;
    localparam logic [7:0] DEADBAND_MAX = 8'h80;
    localparam logic [7:0] PRESC_FULL = 8'hff;
    localparam logic [2:0] PRESC_TOP = 3'h7;

    typedef enum logic [1:0] {
        MODE_COUNTER = 2'b00,
        MODE_COMPARATOR = 2'b01,
        MODE_PWM = 2'b10,
        MODE_PWM_DUAL = 2'b11
    } tcpd_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } tcpd_bus_req_t;

    typedef struct packed {
        logic enable;
        tcpd_mode_t mode;
        logic polaritySelect;
        logic outFunction;
        logic [2:0] prescale;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] pwmValue;
        logic [7:0] deadband;
        logic [1:0] status;
        logic [1:0] mask;
        logic [7:0] prescCount;
        logic primary;
        logic [15:0] rdata;
        logic irq;
    } tcpd_state_t;

endpackage

// ---- rtl/tcpd_sync_edge.sv ----
`timescale 1ns/1ps
module tcpd_sync_edge (
    input wire logic clock,
    input wire logic rst,
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    import tcpd_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic settled;
    } tcpd_sync_t;

    tcpd_sync_t st;
    tcpd_sync_t next_st;
    logic agree;

    assign agree = (st.s2 == st.s3);

    always_comb begin
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.settled = agree ? st.s3 : st.settled;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // A change counts once the second and third stages agree on it
    assign rise = agree & st.s3 & ~st.settled;
    assign fall = agree & ~st.s3 & st.settled;

endmodule // tcpd_sync_edge

// ---- rtl/tcpd_deadband.sv ----
`timescale 1ns/1ps
module tcpd_deadband (
    input wire logic clock,
    input wire logic rst,
    input wire logic level,
    input wire logic [7:0] delay,
    output logic out
);
    import tcpd_pkg::*;

    typedef struct packed {
        logic out;
        logic [7:0] wait_cnt;
    } tcpd_db_t;

    tcpd_db_t st;
    tcpd_db_t next_st;

    always_comb begin
        next_st = st;
        if (!level) begin
            // Falling edges pass at once
            next_st.out = 1'b0;
            next_st.wait_cnt = 8'h00;
        end else if (!st.out) begin
            if (st.wait_cnt >= delay) begin
                next_st.out = 1'b1;
            end else begin
                next_st.wait_cnt = st.wait_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out = st.out;

endmodule // tcpd_deadband

// ---- rtl/tcpd_timer.sv ----
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Operation
// [RULE1] Counter mode with output function: output pin toggles at every reload.
// [RULE2] Counter mode counts rising or falling input edges; same bit sets initial output.
// [RULE3] Loaded start count used once; after each reload counting restarts at 0001H.
// [RULE4] Software loads the count with 0001H before starting counter mode.
// [RULE5] Software disables, configures, loads counts, sets interrupts, then enables last.
// [RULE6] Count advances exactly one per selected input transition.
// [RULE7] Comparator counter mode counts comparator edges of the selected polarity.
// [RULE8] Prescaler bypassed in comparator counter mode.
// [RULE9] PWM first period runs from the loaded start value up to reload.
// [RULE10] PWM, polarity 0: high fraction is (reload minus PWM value) over reload.
// [RULE11] PWM, polarity 1: high fraction is PWM value over reload.
// [RULE12] Dual PWM counts system clocks and drives primary and second outputs.
// [RULE13] Dual PWM counts up; primary output toggles at PWM match, counting continues.
// [RULE14] Dual PWM at reload: interrupt, count set to 0001H, counting continues.
// [RULE15] Dual PWM polarity 1: start high, low at match, high again at reload.
// [RULE16] Dual PWM polarity 0: start low, high at match, low again at reload.
// [RULE17] Second output is the inverse of the primary, apart from deadband.
// [RULE18] Rising edges of both outputs delayed 0 to 128 clocks; falls not delayed.
module tcpd_timer (
    input wire logic clock,
    input wire logic rst,
    input tcpd_pkg::tcpd_bus_req_t busReq,
    output logic [tcpd_pkg::DATA_W-1:0] rdata,
    input wire logic timerIn,
    input wire logic comparatorOut,
    output logic irq,
    output logic timerOut,
    output logic timerOutComp
);
    import tcpd_pkg::*;

    tcpd_state_t st;
    tcpd_state_t next_st;

    logic inRise;
    logic inFall;
    logic cmpRise;
    logic cmpFall;
    logic dbOut;
    logic dbComp;
    logic prescTick;
    logic countTick;
    logic atReload;
    logic atMatch;
    logic isPwm;
    logic isDual;
    logic startNow;
    logic [7:0] prescLast;
    logic [7:0] dbDelay;
    logic [1:0] events;
    logic [1:0] clearBits;
    logic [15:0] ctrlWord;
    logic [15:0] nextCtrl;

    tcpd_sync_edge u_sync_in (
        .clock(clock),
        .rst(rst),
        .pinIn(timerIn),
        .rise(inRise),
        .fall(inFall)
    );

    tcpd_sync_edge u_sync_cmp (
        .clock(clock),
        .rst(rst),
        .pinIn(comparatorOut),
        .rise(cmpRise),
        .fall(cmpFall)
    );

    // Deadband applies only in dual mode; elsewhere one register of latency
    assign isDual = (st.mode == MODE_PWM_DUAL);
    assign isPwm = (st.mode == MODE_PWM) || isDual;
    assign dbDelay = isDual ? st.deadband : 8'h00;

    tcpd_deadband u_db_main (
        .clock(clock),
        .rst(rst),
        .level(st.primary),
        .delay(dbDelay),
        .out(dbOut)
    ); // RULE18

    tcpd_deadband u_db_comp (
        .clock(clock),
        .rst(rst),
        .level(isDual & st.enable & ~st.primary),
        .delay(dbDelay),
        .out(dbComp)
    ); // RULE17

    assign ctrlWord = {8'h00, st.prescale, st.outFunction, st.polaritySelect, st.mode, st.enable};
    assign nextCtrl = busReq.wdata;
    assign prescLast = ~(PRESC_FULL << st.prescale);
    assign prescTick = (st.prescCount == prescLast);

    always_comb begin
        case (st.mode)
            MODE_COUNTER: begin
                countTick = st.polaritySelect ? inFall : inRise; // RULE2 RULE6
            end
            MODE_COMPARATOR: begin
                countTick = st.polaritySelect ? cmpFall : cmpRise; // RULE7 RULE8
            end
            MODE_PWM: begin
                countTick = prescTick;
            end
            MODE_PWM_DUAL: begin
                countTick = 1'b1; // RULE12
            end
            default: begin
                countTick = 1'b0;
            end
        endcase
    end

    assign atReload = (st.count == st.reload);
    assign atMatch = isPwm && (st.count == st.pwmValue);
    assign startNow = busReq.write && (busReq.addr == REG_CTRL) && nextCtrl[CTRL_EN] && !st.enable;
    assign clearBits = (busReq.write && (busReq.addr == REG_STATUS)) ? busReq.wdata[1:0] : 2'b00;

    always_comb begin
        next_st = st;
        events = 2'b00;

        // Prescaler runs only while enabled in single PWM mode
        if (st.enable && (st.mode == MODE_PWM) && !prescTick) begin
            next_st.prescCount = st.prescCount + 8'h01;
        end else begin
            next_st.prescCount = 8'h00;
        end

        // Counting; software writes below take precedence
        if (st.enable && countTick) begin
            if (atReload) begin
                next_st.count = COUNT_RESTART; // RULE3 RULE14
                events[ST_RELOAD] = 1'b1; // RULE14
                if (isPwm) begin
                    next_st.primary = st.polaritySelect; // RULE15 RULE16
                end else if (st.outFunction) begin
                    next_st.primary = ~st.primary; // RULE1
                end
            end else begin
                next_st.count = st.count + 16'h0001; // RULE6 RULE9 RULE13
                if (atMatch) begin
                    // Count equal to PWM value flips the level away from idle
                    next_st.primary = ~st.polaritySelect; // RULE10 RULE11 RULE13
                    events[ST_MATCH] = 1'b1;
                end
            end
        end

        if (!st.enable) begin
            // Idle level follows the polarity bit so a start begins at it
            next_st.primary = st.polaritySelect; // RULE2 RULE15 RULE16
        end

        if (busReq.write) begin
            if (busReq.addr == REG_CTRL) begin
                next_st.enable = nextCtrl[CTRL_EN];
                next_st.mode = tcpd_mode_t'(nextCtrl[CTRL_MODE_LO +: 2]);
                next_st.polaritySelect = nextCtrl[CTRL_POL];
                next_st.outFunction = nextCtrl[CTRL_OUTFN];
                next_st.prescale = nextCtrl[CTRL_PRESC_LO +: 3];
                if (startNow) begin
                    next_st.primary = nextCtrl[CTRL_POL]; // RULE2
                    next_st.prescCount = 8'h00;
                end
            end else if (busReq.addr == REG_COUNT) begin
                next_st.count = busReq.wdata; // RULE9
            end else if (busReq.addr == REG_RELOAD) begin
                next_st.reload = busReq.wdata;
            end else if (busReq.addr == REG_PWM) begin
                next_st.pwmValue = busReq.wdata;
            end else if (busReq.addr == REG_DEADBAND) begin
                // Values above the longest deadband saturate
                if (busReq.wdata[7:0] > DEADBAND_MAX || busReq.wdata[15:8] != 8'h00) begin
                    next_st.deadband = DEADBAND_MAX;
                end else begin
                    next_st.deadband = busReq.wdata[7:0];
                end
            end else if (busReq.addr == REG_MASK) begin
                next_st.mask = busReq.wdata[1:0];
            end
        end

        // New events beat a same-cycle write-one-to-clear
        next_st.status = (st.status & ~clearBits) | events;
        next_st.irq = |(next_st.status & next_st.mask);

        next_st.rdata = 16'h0000;
        if (busReq.read) begin
            if (busReq.addr == REG_CTRL) begin
                next_st.rdata = ctrlWord;
            end else if (busReq.addr == REG_COUNT) begin
                next_st.rdata = st.count;
            end else if (busReq.addr == REG_RELOAD) begin
                next_st.rdata = st.reload;
            end else if (busReq.addr == REG_PWM) begin
                next_st.rdata = st.pwmValue;
            end else if (busReq.addr == REG_DEADBAND) begin
                next_st.rdata = {8'h00, st.deadband};
            end else if (busReq.addr == REG_STATUS) begin
                next_st.rdata = {14'h0000, st.status};
            end else if (busReq.addr == REG_MASK) begin
                next_st.rdata = {14'h0000, st.mask};
            end else if (busReq.addr == REG_PINS) begin
                next_st.rdata = {13'h0000, dbComp, dbOut, st.primary};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st.enable <= 1'b0;
            st.mode <= MODE_COUNTER;
            st.polaritySelect <= 1'b0;
            st.outFunction <= 1'b0;
            st.prescale <= 3'h0;
            st.count <= COUNT_RESET;
            st.reload <= RELOAD_RESET;
            st.pwmValue <= PWM_RESET;
            st.deadband <= DEADBAND_RESET;
            st.status <= 2'b00;
            st.mask <= 2'b00;
            st.prescCount <= 8'h00;
            st.primary <= 1'b0;
            st.rdata <= 16'h0000;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign irq = st.irq;
    assign timerOut = dbOut;
    assign timerOutComp = dbComp;

endmodule // tcpd_timer

// ---- sim/tcpd_properties.sv ----
`timescale 1ns/1ps
module tcpd_properties (
    input wire logic clock,
    input wire logic rst,
    input tcpd_pkg::tcpd_bus_req_t busReq,
    input wire logic [tcpd_pkg::DATA_W-1:0] rdata,
    input wire logic timerIn,
    input wire logic comparatorOut,
    input wire logic irq,
    input wire logic timerOut,
    input wire logic timerOutComp
);
    import tcpd_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence wrRd(logic [7:0] a);
        busReq.write && busReq.addr == a ##1 busReq.read && busReq.addr == a;
    endsequence
    AST_RDATA_IDLE: assert property (!$past(busReq.read) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (busReq.read && busReq.addr > 8'h07 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_RELOAD_RB: assert property (wrRd(REG_RELOAD) |=> rdata == $past(busReq.wdata, 2))
        else $error("reload readback wrong");
    AST_PWM_RB: assert property (wrRd(REG_PWM) |=> rdata == $past(busReq.wdata, 2))
        else $error("match value readback wrong");
    AST_DEADBAND_SAT: assert property (wrRd(REG_DEADBAND) |=>
        rdata == ($past(busReq.wdata, 2) > 16'h0080 ? 16'h0080 : $past(busReq.wdata, 2)))
        else $error("deadband readback wrong");
    AST_MASK_RB: assert property (wrRd(REG_MASK) |=> rdata[1:0] == $past(busReq.wdata[1:0], 2))
        else $error("mask readback wrong");
    AST_MASK_OFF: assert property (busReq.write && busReq.addr == REG_MASK && busReq.wdata[1:0] == 2'h0
        |-> ##2 !irq) else $error("irq high with all sources masked");
    AST_NO_OVERLAP: assert property (!(timerOut && timerOutComp))
        else $error("both outputs high together");
    COV_IRQ: cover property ($rose(irq));
    COV_COMP: cover property ($rose(timerOutComp));
    COV_UNMAPPED: cover property (busReq.read && busReq.addr > 8'h07);
endmodule // tcpd_properties

bind tcpd_timer tcpd_properties chk (.clock(clock), .rst(rst), .busReq(busReq), .rdata(rdata),
    .timerIn(timerIn), .comparatorOut(comparatorOut), .irq(irq), .timerOut(timerOut),
    .timerOutComp(timerOutComp));

// ---- sim/tcpd_pins.sv ----
`timescale 1ns/1ps
module tcpd_pins (
    input wire logic clock,
    input wire logic [1:0] pinReq,
    output logic timerIn,
    output logic comparatorOut
);
    logic [1:0] held = 2'b00;
    // Pads idle low; the driver spaces edges so each is counted once
    always @(posedge clock) begin
        held <= pinReq;
    end
    assign timerIn = held[0];
    assign comparatorOut = held[1];
endmodule // tcpd_pins

// ---- sim/tb_timer_counter_pwm_dual.sv ----
`timescale 1ns/1ps
module tb_timer_counter_pwm_dual;
    import tcpd_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    tcpd_bus_req_t busReq = '0;
    logic [15:0] rdata;
    logic irq, timerOut, timerOutComp, timerIn, comparatorOut;
    logic [1:0] pinReq = 2'b00;
    logic rdPend = 1'b0;
    logic [15:0] expQ[$];
    logic [15:0] mskQ[$];
    logic [15:0] rstVal [7] = '{16'h0, 16'h0001, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] rnd = 16'h0053;
    int num_errors = 0;
    int check_count = 0;
    int hiOut, hiComp, p, d, s, hiP;
    tcpd_timer uut (.clock(clock), .rst(rst), .busReq(busReq), .rdata(rdata), .timerIn(timerIn),
        .comparatorOut(comparatorOut), .irq(irq), .timerOut(timerOut), .timerOutComp(timerOutComp));
    tcpd_pins pins (.clock(clock), .pinReq(pinReq), .timerIn(timerIn), .comparatorOut(comparatorOut));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        busReq.addr <= a;
        busReq.wdata <= v;
        busReq.write <= 1'b1;
        @(posedge clock);
        busReq.write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clock);
        busReq.addr <= a;
        busReq.read <= 1'b1;
        expQ.push_back(e);
        mskQ.push_back(m);
        @(posedge clock);
        busReq.read <= 1'b0;
    endtask
    task automatic wrRd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] e);
        wr(a, v);
        busReq.read <= 1'b1;
        expQ.push_back(e);
        mskQ.push_back(16'hffff);
        @(posedge clock);
        busReq.read <= 1'b0;
    endtask
    task automatic pulse(input int w, input int n);
        repeat (n) begin
            pinReq[w] <= 1'b1;
            repeat (4) @(posedge clock);
            pinReq[w] <= 1'b0;
            repeat (8) @(posedge clock);
        end
    endtask
    task automatic measure(input int n);
        hiOut = 0;
        hiComp = 0;
        repeat (n) begin
            @(negedge clock);
            hiOut += int'(timerOut === 1'b1);
            hiComp += int'(timerOutComp === 1'b1);
        end
        @(posedge clock);
    endtask
    initial begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        rdPend <= busReq.read;
    end
    always @(negedge clock) begin : monitor
        logic [15:0] m;
        if (rdPend) begin
            m = mskQ.pop_front();
            chk("rdata", expQ.pop_front() & m, rdata & m);
        end
    end
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int i = 1; i < 7; i++) rd(i[7:0], rstVal[i], 16'hffff);
        rd(8'h20, 16'h0000, 16'hffff);
        wrRd(REG_DEADBAND, 16'h00c8, 16'h0080);
        for (int pol = 0; pol < 2; pol++) begin
            s = 1;
            wr(REG_CTRL, {11'h0, 1'b1, pol[0], MODE_COUNTER, 1'b0});
            wr(REG_COUNT, s[15:0]);
            wrRd(REG_RELOAD, 16'h0007, 16'h0007);
            wr(REG_STATUS, 16'h0003);
            wrRd(REG_MASK, 16'h0001, 16'h0001);
            wr(REG_CTRL, {11'h0, 1'b1, pol[0], MODE_COUNTER, 1'b1});
            repeat (2) @(posedge clock);
            chk("timerOut", {15'h0, pol[0]}, {15'h0, timerOut});
            pulse(0, 7 - s);
            rd(REG_COUNT, 16'h0007, 16'hffff);
            chk("irq", 16'h0, {15'h0, irq});
            pulse(0, 1);
            rd(REG_COUNT, COUNT_RESTART, 16'hffff);
            chk("timerOut", {15'h0, ~pol[0]}, {15'h0, timerOut});
            chk("irq", 16'h1, {15'h0, irq});
            pulse(0, 2);
            rd(REG_COUNT, 16'h0003, 16'hffff);
        end
        wr(REG_CTRL, {8'h0, 3'h7, 2'b00, MODE_COMPARATOR, 1'b0});
        wr(REG_COUNT, COUNT_RESTART);
        wr(REG_RELOAD, 16'hffff);
        wr(REG_CTRL, {8'h0, 3'h7, 2'b00, MODE_COMPARATOR, 1'b1});
        pulse(0, 2);
        pulse(1, 4);
        rd(REG_COUNT, 16'h0005, 16'hffff);
        for (int md = 0; md < 2; md++) begin
            for (int pol = 0; pol < 2; pol++) begin
                rnd = lfsr(rnd);
                p = 3 + int'(rnd[1:0]);
                d = md ? 2 : 0;
                hiP = pol ? p : 10 - p;
                wr(REG_CTRL, {11'h0, 1'b0, pol[0], md ? MODE_PWM_DUAL : MODE_PWM, 1'b0});
                wr(REG_COUNT, COUNT_RESTART);
                wrRd(REG_RELOAD, 16'h000a, 16'h000a);
                wrRd(REG_PWM, p[15:0], p[15:0]);
                wrRd(REG_DEADBAND, 16'h0002, 16'h0002);
                wr(REG_CTRL, {11'h0, 1'b0, pol[0], md ? MODE_PWM_DUAL : MODE_PWM, 1'b1});
                repeat (30) @(posedge clock);
                measure(40);
                chk("timerOut highs", 16'(4 * (hiP - d)), hiOut[15:0]);
                chk("timerOutComp highs", 16'(md ? 4 * (10 - hiP - d) : 0), hiComp[15:0]);
                if (md == 1) begin
                    rd(REG_STATUS, 16'h0003, 16'h0003);
                    chk("irq", 16'h1, {15'h0, irq});
                    wr(REG_MASK, 16'h0000);
                    repeat (2) @(posedge clock);
                    chk("irq", 16'h0, {15'h0, irq});
                    wr(REG_MASK, 16'h0001);
                end
            end
        end
        // First period from a non-default start is a one-shot run up to reload
        wr(REG_CTRL, {11'h0, 1'b0, 1'b0, MODE_PWM, 1'b0});
        wr(REG_COUNT, 16'h0008);
        wr(REG_STATUS, 16'h0003);
        wr(REG_CTRL, {11'h0, 1'b0, 1'b0, MODE_PWM, 1'b1});
        rd(REG_STATUS, 16'h0000, 16'h0001);
        rd(REG_STATUS, 16'h0001, 16'h0001);
        repeat (3) @(posedge clock);
        give_verdict();
    end
endmodule // tb_timer_counter_pwm_dual
